// >>> rtu_bank.sv
// Purpose: modbus holding-register bank of a remote terminal unit
// Assumes: requests already framed; inputs synchronous to clk_sys
// Notes:   one request per two cycles; answer two cycles after take
//
// How it works
// - serve requests only on network port 4502, not the standard 502.
// - every register is 16 bits and readable; only status and output registers are writable by modbus requests.
// - register 0 returns own station address.
// - register 1 high byte holds received level in negative dBm.
// - level byte reads 255 while radio is unregistered.
// - status bit 7 set at restart; writing one to bit 7 clears it.
// - status bit 6 flags io fault; write-one clears only once fault gone.
// - io fault raised by failed module or io count mismatch.
// - status bit 4 time valid, bit 3 device ok, bit 1 radio fault.
// - register 2 presents packed input data.
// - registers 300-399 hold packed outputs; first switched output is bit 0.
// - registers 400-449 show digital inputs, first event input in bit 0.
// - registers 450-499 show 12-bit analog inputs, upper four bits zero.
// - registers 600-749 hold one 16-bit counter per input, in order.
// - first group counts events, second group counts active seconds.
// - registers 750-799 hold digital outputs; writes drive them.
// - registers 800-899 hold analog outputs, first is first expansion channel.
// - legacy registers 150-153 show 12-bit analog inputs, upper bits zero.
// - legacy registers 500-515 hold counters, first belongs to first event input.
// - sixteen on-off inputs and eight on-off outputs.
// - counters need only follow pulses up to 10 Hz.
// - on io fault all outputs forced off or zero.
`include "rtu_defs.svh"

module rtu_bank #(
    parameter int N_DI      = 16,
    parameter int N_DO      = 8,
    parameter int N_AI      = 4,
    parameter int N_AO      = 4,
    parameter int N_EVENT   = 8,
    parameter int SEC_TICKS = `RTU_CLK_HZ * `RTU_CNT_TICK_S
) (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        nrst,
    // modbus request and answer
    input  wire rtu_pkg::rtu_req_s           req,
    output rtu_pkg::rtu_rsp_s                rsp,
    // unit identity and health
    input  wire logic [7:0]                  station_addr,
    input  wire rtu_pkg::rtu_health_s        health,
    // field inputs
    input  wire logic [N_DI-1:0]             din,
    input  wire logic [N_AI-1:0][11:0]       ain,
    // field outputs
    output logic [N_DO-1:0]                  dout,
    output logic [N_AO-1:0][15:0]            aout
);
    localparam int TW = $clog2(SEC_TICKS + 1);

    rtu_pkg::rtu_state_e   state_q;
    rtu_pkg::rtu_req_s     req_q;
    logic [7:0]            addr_q;
    logic                  restart_q;
    logic                  ioerr_q;
    logic [N_DO-1:0]       dout_q;
    logic [N_AO-1:0][15:0] aout_q;
    logic [N_DI-1:0][15:0] cnt_q;
    logic [N_DI-1:0]       din_q;
    logic [TW-1:0]         tick_cnt_q;
    logic                  sec_tick_q;
    logic [15:0]           rdata_d;
    logic [7:0]            level;
    logic                  fault_now;
    logic                  take;
    logic                  wr;
    logic [15:0]           ra;

    // only frames on our port and our station are served
    assign take = req.valid && state_q == rtu_pkg::RTU_IDLE
                  && req.net_port == `RTU_MODBUS_PORT
                  && req.station == station_addr;
    assign wr = state_q == rtu_pkg::RTU_ANS && req_q.write;
    assign ra = req_q.reg_num;
    assign fault_now = health.io_module_fail || health.io_count_bad;
    assign level = health.registered ? health.level_dbm : `RTU_LEVEL_UNREG;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            state_q <= rtu_pkg::RTU_IDLE;
            req_q   <= '0;
        end
        else
        begin
            case (state_q)
                rtu_pkg::RTU_IDLE:
                begin
                    if (take)
                    begin
                        req_q   <= req;
                        state_q <= rtu_pkg::RTU_ANS;
                    end
                end
                rtu_pkg::RTU_ANS:
                    state_q <= rtu_pkg::RTU_IDLE;
                default:
                    state_q <= rtu_pkg::RTU_IDLE;
            endcase
        end
    end

    // station address follows the strap after reset release
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            addr_q <= 8'h00;
        else
            addr_q <= station_addr;
    end

    // restart flag: reset sets it, write-one clears
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            restart_q <= 1'b1;
        else if (wr && ra == `RTU_REG_STATUS && req_q.wdata[`RTU_ST_RESTART])
            restart_q <= 1'b0;
    end

    // set wins over clear so a lasting fault is never lost
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            ioerr_q <= 1'b0;
        else if (fault_now)
            ioerr_q <= 1'b1;
        else if (wr && ra == `RTU_REG_STATUS && req_q.wdata[`RTU_ST_IOERR])
            ioerr_q <= 1'b0;
    end

    // output images; input, address and counter registers have no write path
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            dout_q <= '0;
            aout_q <= '0;
        end
        else if (wr)
        begin
            if (ra == `RTU_REG_PACKED_OUT || ra == `RTU_REG_DOUT)
                dout_q <= req_q.wdata[N_DO-1:0];
            for (int i = 0; i < N_AO; i++)
            begin
                if (ra == `RTU_REG_AOUT + 16'(i) || ra == `RTU_REG_PACKED_OUT + 16'(i + 1))
                    aout_q[i] <= req_q.wdata;
            end
        end
    end

    // pins: forced off while a fault stands, hence a second flop stage
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            dout <= '0;
            aout <= '0;
        end
        else if (ioerr_q || fault_now)
        begin
            dout <= '0;
            aout <= '0;
        end
        else
        begin
            dout <= dout_q;
            aout <= aout_q;
        end
    end

    // one-second enable for duration counters
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            tick_cnt_q <= '0;
            sec_tick_q <= 1'b0;
        end
        else if (tick_cnt_q == TW'(SEC_TICKS - 1))
        begin
            tick_cnt_q <= '0;
            sec_tick_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            sec_tick_q <= 1'b0;
        end
    end

    // per-input counters; edge detect at clock rate covers 10 Hz easily
    genvar g;
    generate
        for (g = 0; g < N_DI; g++)
        begin : g_cnt
            always_ff @(posedge clk_sys)
            begin
                if (!nrst)
                begin
                    din_q[g] <= din[g]; // an input already high through reset is no event
                    cnt_q[g] <= 16'h0000;
                end
                else
                begin
                    din_q[g] <= din[g];
                    if (g < N_EVENT)
                    begin
                        if (din[g] && !din_q[g])
                            cnt_q[g] <= cnt_q[g] + 16'h0001;
                    end
                    else if (sec_tick_q && din[g])
                        cnt_q[g] <= cnt_q[g] + 16'h0001;
                end
            end
        end
    endgenerate

    // read decode; unmapped numbers read zero
    always_comb
    begin
        rdata_d = 16'h0000;
        if (ra == `RTU_REG_ADDR)
            rdata_d = {8'h00, addr_q};
        else if (ra == `RTU_REG_STATUS)
            rdata_d = {level, restart_q, ioerr_q, 1'b0, health.time_valid,
                       health.dev_ok, 1'b0, health.radio_fault, 1'b0};
        else if (ra == `RTU_REG_PACKED_IN)
            rdata_d = 16'(din);
        else if (ra == `RTU_REG_PACKED_OUT)
            rdata_d = 16'(dout_q);
        else if (ra == `RTU_REG_DIN)
            rdata_d = 16'(din);
        else if (ra == `RTU_REG_DOUT)
            rdata_d = 16'(dout_q);
        for (int i = 0; i < N_AI; i++)
        begin
            if (ra == `RTU_REG_AIN + 16'(i) || ra == `RTU_REG_LEG_AI + 16'(i))
                rdata_d = {4'h0, ain[i]};
        end
        for (int i = 0; i < N_AO; i++)
        begin
            if (ra == `RTU_REG_AOUT + 16'(i) || ra == `RTU_REG_PACKED_OUT + 16'(i + 1))
                rdata_d = aout_q[i];
        end
        for (int i = 0; i < N_DI; i++)
        begin
            if (ra == `RTU_REG_CNT + 16'(i) || ra == `RTU_REG_LEG_CNT + 16'(i))
                rdata_d = cnt_q[i];
        end
    end

    // answer two cycles after the take
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            rsp <= '0;
        else
        begin
            rsp.valid  <= state_q == rtu_pkg::RTU_ANS;
            rsp.served <= state_q == rtu_pkg::RTU_ANS && ra < `RTU_REG_END;
            rsp.rdata  <= state_q == rtu_pkg::RTU_ANS ? rdata_d : 16'h0000;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence s_take;
        take;
    endsequence

    sequence s_answer;
        ##2 rsp.valid;
    endsequence

    a_port_filter: assert property (req.valid && req.net_port != `RTU_MODBUS_PORT |=> state_q == rtu_pkg::RTU_IDLE)
        else $error("request on wrong port taken");
    a_answer_time: assert property (s_take |-> s_answer)
        else $error("answer not two cycles after take");
    a_level_unreg: assert property (state_q == rtu_pkg::RTU_ANS && !health.registered
        && ra == `RTU_REG_STATUS |=> rsp.rdata[15:8] == 8'hff)
        else $error("level byte not 255 when unregistered");
    a_restart_clear: assert property (wr && ra == `RTU_REG_STATUS && req_q.wdata[7] |=> !restart_q)
        else $error("restart flag not cleared");
    a_ioerr_hold: assert property (fault_now |=> ioerr_q)
        else $error("io fault flag cleared while fault stands");
    a_fault_off: assert property (fault_now |=> dout == '0 && aout == '0)
        else $error("outputs not forced off on fault");
    a_ro_ignored: assert property (wr && ra == `RTU_REG_DIN |=> $stable(dout_q) && $stable(aout_q))
        else $error("read-only write changed outputs");
    a_dout_write: assert property (wr && ra == `RTU_REG_DOUT ##1 !(ioerr_q || fault_now)
        |=> dout == $past(req_q.wdata[N_DO-1:0], 2))
        else $error("digital output write not driven");
    a_event_count: assert property (din[0] && !din_q[0] |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
        else $error("event counter missed an edge");

    // status answers are checked one cycle after the answer state
    sequence s_status_read;
        state_q == rtu_pkg::RTU_ANS && ra == `RTU_REG_STATUS;
    endsequence

    a_valid_pulse: assert property (rsp.valid |=> !rsp.valid)
        else $error("answer valid longer than one cycle");
    a_rdata_quiet: assert property (!rsp.valid |-> rsp.rdata == 16'h0000)
        else $error("read data not zero outside an answer");
    a_served_range: assert property (state_q == rtu_pkg::RTU_ANS && ra >= `RTU_REG_END
        |=> rsp.valid && !rsp.served)
        else $error("unmapped register reported as served");
    a_station_filter: assert property (req.valid && req.station != station_addr
        |=> state_q == rtu_pkg::RTU_IDLE)
        else $error("request for another station taken");
    // address register lags the strap by one cycle
    a_addr_read: assert property (state_q == rtu_pkg::RTU_ANS && ra == `RTU_REG_ADDR
        |=> rsp.rdata == {8'h00, $past(station_addr, 2)})
        else $error("station address read wrong");
    a_level_reg: assert property (health.registered ##0 s_status_read
        |=> rsp.rdata[15:8] == $past(health.level_dbm))
        else $error("level byte not the received level");
    a_status_bits: assert property (s_status_read
        |=> rsp.rdata[7:0] == {$past(restart_q), $past(ioerr_q), 1'b0,
                               $past(health.time_valid), $past(health.dev_ok), 1'b0,
                               $past(health.radio_fault), 1'b0})
        else $error("status byte wrong");
    a_ioerr_clear: assert property (wr && ra == `RTU_REG_STATUS && req_q.wdata[`RTU_ST_IOERR] && !fault_now
        |=> !ioerr_q)
        else $error("io fault flag not cleared after fault went");
    a_pin_follow: assert property (!(ioerr_q || fault_now)
        |=> dout == $past(dout_q) && aout == $past(aout_q))
        else $error("output pins do not follow the images");
    a_ain_upper: assert property (state_q == rtu_pkg::RTU_ANS && ra >= `RTU_REG_AIN
        && ra < `RTU_REG_AIN + 16'(N_AI) |=> rsp.rdata[15:12] == 4'h0)
        else $error("analog input upper bits not zero");
    // limitation: a tick pulse needs at least two clocks per second period
    a_tick_pulse: assert property (sec_tick_q |=> !sec_tick_q)
        else $error("second tick longer than one cycle");
    a_dur_count: assert property (sec_tick_q && din[N_EVENT]
        |=> cnt_q[N_EVENT] == $past(cnt_q[N_EVENT]) + 16'h0001)
        else $error("duration counter missed a second");
endmodule // rtu_bank

// >>> rtu_defs.svh
// Purpose: offsets, field positions, port numbers, the unregistered level and timing for the rtu register bank
// Assumes: 16-bit registers addressed by modbus register number
// Notes:   definitions only
`ifndef RTU_DEFS_SVH
`define RTU_DEFS_SVH

`define RTU_MODBUS_PORT     16'h1196
`define RTU_STD_PORT        16'h01f6
`define RTU_REG_ADDR        16'h0000
`define RTU_REG_STATUS      16'h0001
`define RTU_REG_PACKED_IN   16'h0002
`define RTU_REG_LEG_AI      16'h0096
`define RTU_REG_PACKED_OUT  16'h012c
`define RTU_REG_DIN         16'h0190
`define RTU_REG_AIN         16'h01c2
`define RTU_REG_LEG_CNT     16'h01f4
`define RTU_REG_CNT         16'h0258
`define RTU_REG_DOUT        16'h02ee
`define RTU_REG_AOUT        16'h0320
`define RTU_REG_END         16'h0384
`define RTU_ST_RESTART      7
`define RTU_ST_IOERR        6
`define RTU_ST_TIME         4
`define RTU_ST_OK           3
`define RTU_ST_RADIO        1
`define RTU_LEVEL_UNREG     8'hff
`define RTU_CLK_HZ          25000000
`define RTU_CNT_TICK_S      1

`endif

// >>> rtu_master.sv
// Purpose: modbus master model feeding requests into the rtu bank
// Assumes: one request per xfer, two cycles apart
// Notes:   idle fields carry the inverse of the last request
module rtu_master (
    // clock
    input  wire logic         clk_sys,
    // request to the bank
    output rtu_pkg::rtu_req_s req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // held for the one taking edge, then released
    task automatic xfer(input logic wr, input logic [15:0] port, input logic [7:0] stn,
                        input logic [15:0] num, input logic [15:0] wd);
        @(posedge clk_sys);
        #1;
        req = {1'b1, wr, port, stn, num, wd};
        @(posedge clk_sys);
        #1;
        // inverse drops valid and leaves no stale field
        req = ~req;
    endtask
endmodule // rtu_master

// >>> rtu_pkg.sv
// Purpose: types shared by the rtu register bank
// Assumes: nothing beyond the defs header
// Notes:   request and answer travel as packed structs
package rtu_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] net_port;
        logic [7:0]  station;
        logic [15:0] reg_num;
        logic [15:0] wdata;
    } rtu_req_s;

    typedef struct packed {
        logic        valid;
        logic        served;
        logic [15:0] rdata;
    } rtu_rsp_s;

    typedef struct packed {
        logic       io_module_fail;
        logic       io_count_bad;
        logic       time_valid;
        logic       dev_ok;
        logic       radio_fault;
        logic       registered;
        logic [7:0] level_dbm;
    } rtu_health_s;

    typedef enum logic [1:0] {
        RTU_IDLE = 2'b01,
        RTU_ANS  = 2'b10
    } rtu_state_e;
endpackage

// >>> test_rtu_bank.sv
// Purpose: self-checking bench for the rtu register bank
// Assumes: short second tick so duration counts fit the run
// Notes:   answers are matched against a queue of notes
`include "rtu_defs.svh"
module test_rtu_bank;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clk_sys;
    logic                  nrst;
    rtu_pkg::rtu_req_s     req;
    rtu_pkg::rtu_rsp_s     rsp;
    logic [7:0]            station_addr;
    rtu_pkg::rtu_health_s  health;
    logic [15:0]           din;
    logic [3:0][11:0]      ain;
    logic [7:0]            dout;
    logic [3:0][15:0]      aout;
    logic [17:0]           q[$];
    logic [17:0]           note;
    logic [7:0]            img;
    logic [15:0]           aval;
    int                    failures = 0;
    int                    tests_run = 0;
    int                    seed = 32'h00ce;

    initial
    begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end

    rtu_bank #(.SEC_TICKS(10)) DUT (.clk_sys(clk_sys), .nrst(nrst), .req(req), .rsp(rsp),
        .station_addr(station_addr), .health(health), .din(din), .ain(ain), .dout(dout), .aout(aout));
    rtu_master m (.clk_sys(clk_sys), .req(req));

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic rd(input logic [15:0] num, input logic [15:0] exp);
        q.push_back({1'b1, num < 16'd900, exp});
        m.xfer(1'b0, `RTU_MODBUS_PORT, station_addr, num, 16'h0000);
    endtask

    // write answers carry the old value, so only served is noted
    task automatic wr(input logic [15:0] num, input logic [15:0] wd);
        q.push_back({1'b0, 1'b1, 16'h0000});
        m.xfer(1'b1, `RTU_MODBUS_PORT, station_addr, num, wd);
    endtask

    function automatic logic [15:0] stat(input logic rs, input logic ie);
        return {health.registered ? health.level_dbm : 8'hff, rs, ie, 1'b0, health.time_valid,
                health.dev_ok, 1'b0, health.radio_fault, 1'b0};
    endfunction

    always @(posedge clk_sys)
    begin
        #1;
        if (rsp.valid === 1'b1)
        begin
            if (q.size() == 0)
                check(18'h1, 18'h0);
            else
            begin
                note = q.pop_front();
                check({note[17], rsp.served, note[17] ? rsp.rdata : 16'h0000}, note);
            end
        end
    end

    initial
    begin
        #2000000;
        failures++;
        conclude();
    end

    initial
    begin
        nrst = 0;
        din = '0;
        ain = '0;
        station_addr = 8'h2a;
        health = {1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h5a};
        cyc(6);
        nrst = 1;
        for (int k = 0; k < 3; k++)
        begin
            din[0] = 1'b1;
            cyc(2);
            din[0] = 1'b0;
            cyc(2);
        end
        din[8] = 1'b1;
        cyc(30);
        din[8] = 1'b0;
        rd(`RTU_REG_CNT, 16'h0003);
        rd(`RTU_REG_LEG_CNT, 16'h0003);
        rd(`RTU_REG_CNT + 16'h0008, 16'h0003);
        rd(`RTU_REG_LEG_CNT + 16'h0008, 16'h0003);
        rd(`RTU_REG_CNT + 16'h0001, 16'h0000);
        rd(`RTU_REG_ADDR, {8'h00, station_addr});
        rd(`RTU_REG_STATUS, stat(1'b1, 1'b0));
        for (int k = 0; k < 4; k++)
        begin
            // let the previous answer latch its status before health moves
            cyc(1);
            health[11:8] = 4'($random(seed));
            health.level_dbm = 8'($random(seed));
            rd(`RTU_REG_STATUS, stat(1'b1, 1'b0));
        end
        wr(`RTU_REG_STATUS, 16'h0080);
        rd(`RTU_REG_STATUS, stat(1'b0, 1'b0));
        img = 8'($random(seed));
        aval = 16'($random(seed));
        wr(`RTU_REG_DOUT, {8'h00, img});
        wr(`RTU_REG_AOUT, aval);
        cyc(2);
        check(dout, img);
        check(aout[0], aval);
        rd(`RTU_REG_PACKED_OUT, {8'h00, img});
        rd(`RTU_REG_PACKED_OUT + 16'h0001, aval);
        // fault on module loss, cleared once it has gone
        health.io_module_fail = 1'b1;
        cyc(2);
        health.io_module_fail = 1'b0;
        rd(`RTU_REG_STATUS, stat(1'b0, 1'b1));
        wr(`RTU_REG_STATUS, 16'h0040);
        rd(`RTU_REG_STATUS, stat(1'b0, 1'b0));
        health.io_count_bad = 1'b1;
        cyc(2);
        check(dout, 8'h00);
        check(aout[0], 16'h0000);
        wr(`RTU_REG_STATUS, 16'h0040);
        rd(`RTU_REG_STATUS, stat(1'b0, 1'b1));
        health.io_count_bad = 1'b0;
        wr(`RTU_REG_STATUS, 16'h0040);
        rd(`RTU_REG_STATUS, stat(1'b0, 1'b0));
        cyc(2);
        check(dout, img);
        din = 16'($random(seed));
        for (int i = 0; i < 4; i++)
            ain[i] = 12'($random(seed));
        cyc(2);
        rd(`RTU_REG_DIN, din);
        rd(`RTU_REG_PACKED_IN, din);
        for (int i = 0; i < 4; i++)
        begin
            rd(`RTU_REG_AIN + 16'(i), {4'h0, ain[i]});
            rd(`RTU_REG_LEG_AI + 16'(i), {4'h0, ain[i]});
        end
        wr(`RTU_REG_DIN, 16'hffff);
        wr(`RTU_REG_ADDR, 16'hffff);
        rd(`RTU_REG_DIN, din);
        rd(`RTU_REG_ADDR, {8'h00, station_addr});
        m.xfer(1'b0, `RTU_STD_PORT, station_addr, `RTU_REG_ADDR, 16'h0000);
        m.xfer(1'b0, `RTU_MODBUS_PORT, station_addr + 8'h01, `RTU_REG_ADDR, 16'h0000);
        rd(16'h03b6, 16'h0000);
        cyc(4);
        nrst = 0;
        cyc(2);
        nrst = 1;
        cyc(1);
        check(dout, 8'h00);
        rd(`RTU_REG_STATUS, stat(1'b1, 1'b0));
        rd(`RTU_REG_CNT, 16'h0000);
        cyc(4);
        check(18'(q.size()), 18'h0);
        conclude();
    end
endmodule // test_rtu_bank
